// file: pkg/pwr_mon_pkg.sv
/*
  shared types and constants for the power monitor state control:
  power states, configuration and result carriers, timing figures.
  assumes a 10 MHz core clock and 14-bit unsigned adc samples.
*/
package pwr_mon_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ            = 10;
  localparam int READ_MIN_US        = 10;   // least low time on the pin
  localparam int READ_MIN_CYC       = READ_MIN_US * CLK_MHZ;
  localparam int WAKE_TO_INT_US     = 100;  // sleep to integrate delay
  localparam int WAKE_TO_INT_CYC    = WAKE_TO_INT_US * CLK_MHZ;
  localparam int SLEEP_TIMEOUT_MS   = 100;
  localparam int SLEEP_TIMEOUT_CYC  = SLEEP_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int CONV_11_US         = 5;    // one 11-bit conversion
  localparam int CONV_14_US         = 20;   // one 14-bit conversion
  localparam int CONV_11_CYC        = CONV_11_US * CLK_MHZ;
  localparam int CONV_14_CYC        = CONV_14_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int SMP_W   = 14;
  localparam int PROD_W  = 2 * SMP_W;
  localparam int ACC_W   = 40;
  localparam int CNT_W   = 12;
  localparam int RES_W   = 16;
  localparam int DAC_W   = 10;
  localparam int TICK_W  = 10;
  localparam int LOW_W   = 8;
  localparam int WAKE_W  = 11;
  localparam int SLP_W   = 24;
  localparam int DIV_N_W = 6;

  localparam logic [CNT_W-1:0] MAX_SAMPLES  = 12'h800;
  localparam logic [3:0]       MAX_SMPL_SEL = 4'hB;
  localparam int               PWR_NORM_SH  = PROD_W - RES_W;
  localparam int               SMP_NORM_SH  = RES_W - SMP_W;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INTEGRATE = 3'h1,
    ST_READ      = 3'h2,
    ST_SLEEP     = 3'h4
  } power_state_t;

  typedef enum logic [1:0] {
    MX_POWER_PIN  = 2'h0,
    MX_SENSE_FREE = 2'h1,
    MX_BUS_FREE   = 2'h2,
    MX_POWER_FREE = 2'h3
  } measurement_select_t;

  typedef struct packed {
    logic                pin_override;
    logic                integrate_enable_bit;
    logic                sleep_bit;
    measurement_select_t measurement_select;
    logic                res_14bit;           // 0: 11-bit, 1: 14-bit
    logic                post_filter;
    logic [3:0]          sample_count_sel;
    logic [2:0]          current_digital_gain; // gain 2**n, 1x..128x
    logic [1:0]          voltage_digital_gain; // gain 2**n, 1x..8x
  } config_t;

  typedef struct packed {
    logic [RES_W-1:0] power_result;
    logic [RES_W-1:0] sense_result;
    logic [RES_W-1:0] bus_result;
  } results_t;

endpackage

// file: hdl/seq_divider.sv
/*
  unsigned restoring divider, one quotient bit per clock.
  assumes start only while idle and a nonzero divisor.
*/
`timescale 1ns/1ps

module seq_divider
  import pwr_mon_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             start_i,
  input  wire logic [ACC_W-1:0] dividend_i,
  input  wire logic [CNT_W-1:0] divisor_i,
  output logic                  busy_o,
  output logic                  done_o,
  output logic [ACC_W-1:0]      quotient_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               busy;
    logic               done;
    logic [DIV_N_W-1:0] cnt;
    logic [ACC_W-1:0]   quo;
    logic [CNT_W:0]     rem;
    logic [CNT_W-1:0]   den;
  } div_st_t;

  div_st_t st;
  div_st_t next_st;
  logic [CNT_W:0] trial;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    trial = {st.rem[CNT_W-1:0], st.quo[ACC_W-1]};
    if (start_i && !st.busy) begin
      next_st.busy = 1'b1;
      next_st.cnt  = '0;
      next_st.quo  = dividend_i;
      next_st.rem  = '0;
      next_st.den  = divisor_i;
    end else if (st.busy) begin
      if (trial >= {1'b0, st.den}) begin
        next_st.rem = trial - {1'b0, st.den};
        next_st.quo = {st.quo[ACC_W-2:0], 1'b1};
      end else begin
        next_st.rem = trial;
        next_st.quo = {st.quo[ACC_W-2:0], 1'b0};
      end
      next_st.cnt = st.cnt + 1'b1;
      if (st.cnt == DIV_N_W'(ACC_W - 1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o     = st.busy;
  assign done_o     = st.done;
  assign quotient_o = st.quo;

endmodule

// file: hdl/power_monitor_state_control.sv
/*
  power state sequencer and measurement datapath of a high-side
  power monitor: integrate, read and sleep states, sample
  accumulation, averaging, digital gain and the 10-bit dac code.
  assumes adc samples on the core clock, settled when the sample
  strobe is high; the state pin is asynchronous to the clock.
*/
`timescale 1ns/1ps

module power_monitor_state_control
  import pwr_mon_pkg::*;
#(
  parameter int SLEEP_TIMEOUT_CYCLES = SLEEP_TIMEOUT_CYC
)(
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                state_pin_i,
  input  wire pwr_mon_pkg::config_t cfg_i,
  input  wire logic [SMP_W-1:0]    bus_sample_i,
  input  wire logic [SMP_W-1:0]    sense_sample_i,
  output pwr_mon_pkg::power_state_t power_state_o,
  output logic                     integrating_o,
  output logic                     bias_enable_o,
  output logic                     sample_strobe_o,
  output logic [DAC_W-1:0]         dac_code_o,
  output logic                     dac_update_o,
  output pwr_mon_pkg::results_t    results_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] samples_of(input logic [3:0] s);
    logic [3:0] e;
    e = (s > MAX_SMPL_SEL) ? MAX_SMPL_SEL : s;
    return CNT_W'(1) << e;
  endfunction

  function automatic logic [TICK_W-1:0] period_of(
    input config_t c
  );
    logic [TICK_W-1:0] p;
    p = c.res_14bit ? TICK_W'(CONV_14_CYC) : TICK_W'(CONV_11_CYC);
    if (c.post_filter) begin
      p = p << 1;
    end
    if (c.measurement_select == MX_POWER_PIN ||
        c.measurement_select == MX_POWER_FREE) begin
      p = p << 1;  // bus and sense converted in turn
    end
    return p;
  endfunction

  function automatic logic [RES_W-1:0] saturate(input logic [31:0] v);
    return (v[31:RES_W] != '0) ? {RES_W{1'b1}} : v[RES_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                pin_meta;
    logic                pin_sync;
    power_state_t        pstate;
    logic [LOW_W-1:0]    low_cnt;
    logic [SLP_W-1:0]    sleep_cnt;
    logic [WAKE_W-1:0]   wake_cnt;
    logic [TICK_W-1:0]   tick_cnt;
    logic [ACC_W-1:0]    acc;
    logic [CNT_W-1:0]    nsamp;
    logic                full;
    logic                calc;
    measurement_select_t calc_mode;
    results_t            res;
    logic [DAC_W-1:0]    dac;
    logic                dac_upd;
  } ctl_st_t;

  ctl_st_t st;
  ctl_st_t next_st;

  logic             cmd_int;
  logic             cmd_read;
  logic             free_run;
  logic             tick;
  logic             end_period;
  logic [PROD_W-1:0] product;
  logic [ACC_W-1:0] add_val;
  logic [31:0]      scaled;
  logic             div_start;
  logic             div_done;
  logic [ACC_W-1:0] quotient;
  logic [ACC_W-1:0] div_dividend;
  logic [CNT_W-1:0] div_divisor;
  logic [RES_W-1:0] sat;

  seq_divider u_div (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .start_i    (div_start),
    .dividend_i (div_dividend),
    .divisor_i  (div_divisor),
    .busy_o     (),
    .done_o     (div_done),
    .quotient_o (quotient)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.dac_upd = 1'b0;
    next_st.pin_meta = state_pin_i;
    next_st.pin_sync = st.pin_meta;

    // override steers control; pin low must persist for read entry
    cmd_int  = cfg_i.pin_override ? cfg_i.integrate_enable_bit
                                  : st.pin_sync;
    cmd_read = cfg_i.pin_override ? !cfg_i.integrate_enable_bit
             : (st.low_cnt >= LOW_W'(READ_MIN_CYC));
    if (st.pin_sync) begin
      next_st.low_cnt = '0;
    end else if (st.low_cnt < LOW_W'(READ_MIN_CYC)) begin
      next_st.low_cnt = st.low_cnt + 1'b1;
    end

    free_run = (cfg_i.measurement_select != MX_POWER_PIN);
    product  = bus_sample_i * sense_sample_i;
    case (cfg_i.measurement_select)
      MX_SENSE_FREE: add_val = ACC_W'(sense_sample_i);
      MX_BUS_FREE:   add_val = ACC_W'(bus_sample_i);
      default:       add_val = ACC_W'(product);
    endcase

    tick = (st.pstate == ST_INTEGRATE) && !st.full &&
           (st.tick_cnt == period_of(cfg_i) - 1'b1);
    end_period = 1'b0;
    div_start  = 1'b0;
    div_dividend = st.acc;
    div_divisor  = st.nsamp;

    // ------------------------------------------------------------
    // integration
    // ------------------------------------------------------------
    if (st.pstate == ST_INTEGRATE && !st.full) begin
      next_st.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;
      if (tick) begin
        next_st.acc   = st.acc + add_val;
        next_st.nsamp = st.nsamp + 1'b1;
        if (free_run &&
            st.nsamp + 1'b1 == samples_of(cfg_i.sample_count_sel)) begin
          end_period = 1'b1;
        end else if (!free_run && st.nsamp + 1'b1 == MAX_SAMPLES) begin
          end_period   = 1'b1;
          next_st.full = 1'b1;   // capped: stop until integrate is entered again
        end
      end
    end

    // ------------------------------------------------------------
    // power states
    // ------------------------------------------------------------
    case (st.pstate)
      ST_INTEGRATE: begin
        if (cfg_i.sleep_bit) begin
          next_st.pstate = ST_SLEEP;
        end else if (cmd_read) begin
          next_st.pstate    = ST_READ;
          next_st.sleep_cnt = '0;
          next_st.tick_cnt  = '0;
          // a free-run period that closes on this edge is still kept
          end_period = end_period || (!free_run && !st.full &&
                       (next_st.nsamp != '0));
          if (free_run && !end_period) begin
            next_st.acc   = '0;  // partial free-run period dropped
            next_st.nsamp = '0;
          end
        end
      end
      ST_READ: begin
        next_st.sleep_cnt = st.sleep_cnt + 1'b1;
        if (cfg_i.sleep_bit) begin
          next_st.pstate = ST_SLEEP;
        end else if (cmd_int) begin
          next_st.pstate = ST_INTEGRATE;
          next_st.full   = 1'b0;
        end else if (st.sleep_cnt >=
                     SLP_W'(SLEEP_TIMEOUT_CYCLES - 1)) begin
          next_st.pstate = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (cmd_int && !cfg_i.sleep_bit) begin
          next_st.wake_cnt = st.wake_cnt + 1'b1;
          if (st.wake_cnt == WAKE_W'(WAKE_TO_INT_CYC - 1)) begin
            next_st.pstate   = ST_INTEGRATE;
            next_st.wake_cnt = '0;
            next_st.tick_cnt = '0;
            next_st.full     = 1'b0;
          end
        end else begin
          next_st.wake_cnt = '0;
        end
      end
      default: begin
        next_st.pstate = ST_SLEEP;
      end
    endcase

    if (end_period) begin
      div_start         = 1'b1;
      // divide what the period holds, last sample included
      div_dividend      = next_st.acc;
      div_divisor       = next_st.nsamp;
      next_st.calc      = 1'b1;
      next_st.calc_mode = cfg_i.measurement_select;
      next_st.acc       = '0;
      next_st.nsamp     = '0;
    end

    // ------------------------------------------------------------
    // average done: gain, results, dac
    // ------------------------------------------------------------
    case (st.calc_mode)
      MX_SENSE_FREE: scaled = (32'(quotient[SMP_W-1:0]) << SMP_NORM_SH)
                      << cfg_i.current_digital_gain;
      MX_BUS_FREE:   scaled = (32'(quotient[SMP_W-1:0]) << SMP_NORM_SH)
                      << cfg_i.voltage_digital_gain;
      default:       scaled = ((32'(quotient[PROD_W-1:0]) >> PWR_NORM_SH)
                      << cfg_i.current_digital_gain)
                      << cfg_i.voltage_digital_gain;
    endcase
    sat = saturate(scaled);
    if (div_done && st.calc) begin
      next_st.calc = 1'b0;
      case (st.calc_mode)
        MX_SENSE_FREE: next_st.res.sense_result = sat;
        MX_BUS_FREE:   next_st.res.bus_result   = sat;
        default:       next_st.res.power_result = sat;
      endcase
      // a result computed for another selection never reaches the dac
      if (st.calc_mode == cfg_i.measurement_select) begin
        next_st.dac     = sat[RES_W-1 -: DAC_W];
        next_st.dac_upd = 1'b1;
      end
    end

    // sleep wipes all measurement state, pending average included
    if (next_st.pstate == ST_SLEEP && st.pstate != ST_SLEEP) begin
      next_st.acc      = '0;
      next_st.nsamp    = '0;
      next_st.res      = '0;
      next_st.dac      = '0;
      next_st.calc     = 1'b0;
      next_st.full     = 1'b0;
      next_st.tick_cnt = '0;
      next_st.wake_cnt = '0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st           <= '0;
      st.pstate    <= ST_SLEEP;
      st.calc_mode <= MX_POWER_PIN;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign power_state_o   = st.pstate;
  assign integrating_o   = (st.pstate == ST_INTEGRATE) && !st.full;
  assign bias_enable_o   = (st.pstate != ST_SLEEP);
  assign sample_strobe_o = tick;
  assign dac_code_o      = st.dac;
  assign dac_update_o    = st.dac_upd;
  assign results_o       = st.res;

endmodule

// file: testbench/pwr_mon_checker.sv
/*
  port assertions for the power monitor state control.
  assumes a bind onto the design top and a single clock domain.
*/
`timescale 1ns/1ps

module pwr_mon_checker
  import pwr_mon_pkg::*;
#(
  parameter int SLEEP_TIMEOUT_CYCLES = SLEEP_TIMEOUT_CYC
)(
  input wire logic                     clk_i,
  input wire logic                     arst_n_i,
  input wire logic                     state_pin_i,
  input wire pwr_mon_pkg::config_t      cfg_i,
  input wire pwr_mon_pkg::power_state_t power_state_o,
  input wire logic                     integrating_o,
  input wire logic                     bias_enable_o,
  input wire logic                     sample_strobe_o,
  input wire logic [DAC_W-1:0]         dac_code_o,
  input wire logic                     dac_update_o,
  input wire pwr_mon_pkg::results_t     results_o
);
  localparam int WAKE_MIN = WAKE_TO_INT_CYC - 2;
  logic              pin_s1;
  logic              pin_s2;
  logic              cmd;
  logic [WAKE_W-1:0] wake_cnt;
  logic [SLP_W-1:0]  read_cnt;
  logic [RES_W-1:0]  sel_res;
  measurement_select_t sel_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  assign cmd = cfg_i.pin_override ? cfg_i.integrate_enable_bit : pin_s2;
  // the dac pulse reflects the selection seen one edge earlier
  always_comb begin
    case (sel_q)
      MX_SENSE_FREE: sel_res = results_o.sense_result;
      MX_BUS_FREE:   sel_res = results_o.bus_result;
      default:       sel_res = results_o.power_result;
    endcase
  end
  // saturating, so a long wake wait never wraps back under the bound
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1   <= 1'b0;
      pin_s2   <= 1'b0;
      wake_cnt <= '0;
      read_cnt <= '0;
      sel_q    <= MX_POWER_PIN;
    end else begin
      sel_q    <= cfg_i.measurement_select;
      pin_s1   <= state_pin_i;
      pin_s2   <= pin_s1;
      wake_cnt <= (cmd && !cfg_i.sleep_bit) ?
                  wake_cnt + WAKE_W'(wake_cnt != '1) : '0;
      read_cnt <= (power_state_o == ST_READ) ? read_cnt + 24'h000001
                                             : 24'h000000;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_read_entry;
    $rose(power_state_o == ST_READ);
  endsequence
  sequence s_wake;
    $past(power_state_o) == ST_SLEEP && power_state_o == ST_INTEGRATE;
  endsequence

  state_onehot_a: assert property (
    power_state_o inside {ST_INTEGRATE, ST_READ, ST_SLEEP})
    else $error("power state not one of three");
  sleep_bias_a: assert property (
    bias_enable_o == (power_state_o != ST_SLEEP))
    else $error("bias wrong for state");
  sleep_clear_a: assert property (
    power_state_o == ST_SLEEP |-> results_o == '0 && dac_code_o == '0)
    else $error("results kept in sleep");
  sleep_force_a: assert property (
    cfg_i.sleep_bit |=> power_state_o == ST_SLEEP)
    else $error("sleep bit ignored");
  override_int_a: assert property (
    cfg_i.pin_override && cfg_i.integrate_enable_bit && !cfg_i.sleep_bit
    && power_state_o == ST_READ |=> power_state_o == ST_INTEGRATE)
    else $error("override enable did not integrate");
  override_read_a: assert property (
    cfg_i.pin_override && !cfg_i.integrate_enable_bit && !cfg_i.sleep_bit
    && power_state_o == ST_INTEGRATE |=> power_state_o == ST_READ)
    else $error("override clear did not read");
  pin_read_a: assert property (
    s_read_entry and !cfg_i.pin_override |-> $past(state_pin_i, 100) == 1'b0)
    else $error("read entered on short low pin");
  wake_delay_a: assert property (
    s_wake |-> wake_cnt >= WAKE_MIN)
    else $error("wake delay too short");
  int_state_a: assert property (
    integrating_o |-> power_state_o == ST_INTEGRATE)
    else $error("integrating outside integrate");
  strobe_int_a: assert property (
    sample_strobe_o |-> integrating_o)
    else $error("sample while not integrating");
  dac_hold_a: assert property (
    $changed(dac_code_o) |-> dac_update_o || power_state_o == ST_SLEEP)
    else $error("dac changed without update");
  dac_select_a: assert property (
    dac_update_o |-> dac_code_o == sel_res[RES_W-1 -: DAC_W])
    else $error("dac not upper bits of selected result");
  sleep_timer_a: assert property (
    power_state_o == ST_READ |-> read_cnt <= SLEEP_TIMEOUT_CYCLES)
    else $error("read outlived sleep timeout");
endmodule

bind power_monitor_state_control pwr_mon_checker #(
  .SLEEP_TIMEOUT_CYCLES(SLEEP_TIMEOUT_CYCLES)
) u_pwr_mon_checker (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .state_pin_i(state_pin_i),
  .cfg_i(cfg_i), .power_state_o(power_state_o),
  .integrating_o(integrating_o), .bias_enable_o(bias_enable_o),
  .sample_strobe_o(sample_strobe_o), .dac_code_o(dac_code_o),
  .dac_update_o(dac_update_o), .results_o(results_o)
);

// file: testbench/host_model.sv
/*
  host model: drives the state pin, feeds adc samples, samples dac.
  assumes samples are taken in the strobe cycle only.
*/
`timescale 1ns/1ps

module host_model
  import pwr_mon_pkg::*;
#(
  parameter logic [SMP_W-1:0] BUS_LEVEL   = 14'h0800,
  parameter logic [SMP_W-1:0] SENSE_LEVEL = 14'h1000
)(
  input  wire logic             clk_i,
  input  wire logic             cmd_i,
  input  wire logic             strobe_i,
  input  wire logic             dac_update_i,
  input  wire logic [DAC_W-1:0] dac_code_i,
  output logic                  state_pin_o,
  output logic [SMP_W-1:0]      bus_sample_o,
  output logic [SMP_W-1:0]      sense_sample_o,
  output logic [DAC_W-1:0]      dac_seen_o
);
  initial state_pin_o = 1'b0;
  initial dac_seen_o = 10'h000;
  // pin follows the command one cycle later; the caller sets how long lows last
  always @(posedge clk_i) begin
    state_pin_o <= cmd_i;
    if (dac_update_i) begin
      dac_seen_o <= dac_code_i;
    end
  end
  // outside the strobe the inverse shows, so a stale sample cannot pass
  assign bus_sample_o   = strobe_i ? BUS_LEVEL : ~BUS_LEVEL;
  assign sense_sample_o = strobe_i ? SENSE_LEVEL : ~SENSE_LEVEL;
endmodule

// file: testbench/tb.sv
/*
  testbench for the power monitor state control.
  assumes host_model beside the design and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(g, e) check((g) === (e), `__LINE__)

module tb;
  import pwr_mon_pkg::*;
  localparam int SLEEP_T = 300;
  localparam int TMO     = 400;
  logic             clk_i    = 1'b0;
  logic             arst_n_i = 1'b0;
  logic             cmd      = 1'b1;
  config_t          cfg      = '0;
  logic             pin;
  logic [SMP_W-1:0] bus_smp;
  logic [SMP_W-1:0] sense_smp;
  power_state_t     power_state_o;
  logic             integrating_o;
  logic             strobe;
  logic [DAC_W-1:0] dac_code_o;
  logic             dac_update_o;
  logic [DAC_W-1:0] dac_seen;
  results_t         results_o;
  int               err_total = 0;
  int               n_tests   = 0;
  int               n;
  // sense<<2, bus<<2, power>>12, each shifted by gain and saturated
  logic [RES_W-1:0] exp_res [9] = '{16'h4000, 16'h8000, 16'hFFFF,
    16'h2000, 16'h4000, 16'h8000, 16'h0800, 16'h2000, 16'h8000};

  always #50 clk_i = ~clk_i;

  power_monitor_state_control #(
    .SLEEP_TIMEOUT_CYCLES(SLEEP_T)
  ) u_power_monitor_state_control (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .state_pin_i(pin), .cfg_i(cfg),
    .bus_sample_i(bus_smp), .sense_sample_i(sense_smp),
    .power_state_o(power_state_o), .integrating_o(integrating_o),
    .bias_enable_o(), .sample_strobe_o(strobe), .dac_code_o(dac_code_o),
    .dac_update_o(dac_update_o), .results_o(results_o)
  );

  host_model u_host_model (
    .clk_i(clk_i), .cmd_i(cmd), .strobe_i(strobe),
    .dac_update_i(dac_update_o), .dac_code_i(dac_code_o),
    .state_pin_o(pin), .bus_sample_o(bus_smp),
    .sense_sample_o(sense_smp), .dac_seen_o(dac_seen)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input bit ok, input int ln);
    n_tests++;
    if (!ok) begin
      err_total++;
      $display("BAD %0t mismatch at line %0d", $time, ln);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_st(input power_state_t s, input int lim);
    n = 0;
    while (power_state_o !== s) begin
      if (n == lim) begin
        check(1'b0, `__LINE__);
        results();
      end
      cyc(1);
      n++;
    end
  endtask

  // returns in the cycle that shows the update pulse
  task automatic wait_upd();
    int k;
    k = 0;
    do begin
      if (k == TMO) begin
        check(1'b0, `__LINE__);
        results();
      end
      cyc(1);
      k++;
    end while (dac_update_o !== 1'b1);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    cfg.sleep_bit = 1'b1;
    cyc(8);
    arst_n_i = 1'b1;
    `CHK(power_state_o, ST_SLEEP);
    cyc(1200);
    `CHK(power_state_o, ST_SLEEP);
    cfg.sleep_bit = 1'b0;
    wait_st(ST_INTEGRATE, 1100);
    `CHK(n >= WAKE_TO_INT_CYC - 2, 1'b1);
    `CHK(integrating_o, 1'b1);
    for (int i = 0; i < 9; i++) begin
      cfg.measurement_select = measurement_select_t'(i / 3 + 1);
      cfg.current_digital_gain = 3'(i % 3);
      cfg.voltage_digital_gain = 2'(i % 3);
      cfg.sample_count_sel = 4'(i % 2);
      wait_upd();
      wait_upd();
      `CHK(dac_code_o, exp_res[i][15:6]);
      case (i / 3)
        0: `CHK(results_o.sense_result, exp_res[i]);
        1: `CHK(results_o.bus_result, exp_res[i]);
        default: `CHK(results_o.power_result, exp_res[i]);
      endcase
    end
    cfg.measurement_select = MX_POWER_PIN;
    cfg.current_digital_gain = 3'h0;
    cfg.voltage_digital_gain = 2'h0;
    cyc(300);
    cmd = 1'b0;
    cyc(50);
    cmd = 1'b1;
    cyc(150);
    `CHK(power_state_o, ST_INTEGRATE);
    cmd = 1'b0;
    wait_st(ST_READ, 200);
    `CHK(n >= READ_MIN_CYC, 1'b1);
    `CHK(integrating_o, 1'b0);
    wait_upd();
    `CHK(results_o.power_result, 16'h0800);
    cyc(1);
    `CHK(dac_seen, 10'h020);
    wait_st(ST_SLEEP, TMO);
    `CHK(results_o, 48'h0);
    `CHK(dac_code_o, 10'h000);
    cfg.pin_override = 1'b1;
    cfg.integrate_enable_bit = 1'b1;
    wait_st(ST_INTEGRATE, 1100);
    `CHK(n >= WAKE_TO_INT_CYC - 2, 1'b1);
    for (int k = 0; k < 2; k++) begin
      cfg.integrate_enable_bit = 1'b0;
      cyc(2);
      `CHK(power_state_o, ST_READ);
      cyc(200);
      `CHK(power_state_o, ST_READ);
      cfg.integrate_enable_bit = 1'b1;
      cyc(2);
      `CHK(power_state_o, ST_INTEGRATE);
    end
    cfg.sleep_bit = 1'b1;
    cyc(2);
    `CHK(power_state_o, ST_SLEEP);
    results();
  end
endmodule
